// ### fsbm_defs.svh
// Purpose: constants for the flash security and boot mapping block
// Assumes: 8-bit register port, programmed nonvolatile bit reads as 0
// Notes:   offsets, fields, reset values and counts
//
// Contract
// - user flash is 64K bytes in 512 pages of 128 bytes
// - user flash readable and writable by software and hardware mode
// - boot flash reachable only by hardware mode, never by software
// - software writes security upper nibble; lock nibble only in hardware mode
// - level zero enables no protection
// - level one refuses hardware programming of user and boot flash
// - level two also refuses hardware verify reads
// - level three also disables external code execution
// - level from highest programmed lock bit; internal and software always allowed
// - top lock bit has no storage
// - boot-enable bit maps boot flash at F000h-FFFFh; clearing unmaps
// - boot-force pin low at reset sets boot-enable, vector F000h
// - programmed boot-jump bit at reset sets boot-enable, vector F000h
// - reset copies double-speed start bit into clock-control double-speed bit
// - aux bit 2 reads zero; general flag at bit 3
// - aux bit 0 selects second data pointer when one
// - aux register resets with bits 2 and 0 cleared
// - security byte bits 5 to 3 always read unprogrammed
// - full chip erase returns all nonvolatile bytes to unprogrammed
// - boot vector byte is upper eight bits of loader address; here the boot vector is fixed at F000h
// - eight-bit software security byte blocks loader commands; here the byte is only stored and read back
`ifndef FSBM_DEFS_SVH
`define FSBM_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define FSBM_AUX1_OFF      8'ha2
`define FSBM_HSB_OFF       8'hb0
`define FSBM_SBV_OFF       8'hb1
`define FSBM_SSB_OFF       8'hb2
`define FSBM_STAT_OFF      8'hb3
// ****************************************
// fields
// ****************************************
`define FSBM_AUX_DPS       0
`define FSBM_AUX_GF        3
`define FSBM_AUX_BOOT      5
`define FSBM_HSB_X2B       7
`define FSBM_HSB_BOOT_JUMP_BIT      6
`define FSBM_HSB_RSV_MASK  8'h38
`define FSBM_HSB_MSN_MASK  8'hc0
`define FSBM_HSB_LSN_MASK  8'h07
`define FSBM_ERASED        8'hff
`define FSBM_AUX_RESET     8'h00
`define FSBM_PAGES         512
`define FSBM_PAGE_BYTES    128
`define FSBM_BOOT_BASE     16'hf000
`define FSBM_USER_VEC      16'h0000
`endif

// ### fsbm_pkg.sv
// Purpose: types for the flash security and boot mapping block
// Assumes: nothing
// Notes:   access request carried as one struct
package fsbm_pkg;
   typedef enum logic [1:0] {
      FSBM_LVL0 = 2'b00,
      FSBM_LVL1 = 2'b01,
      FSBM_LVL2 = 2'b11,
      FSBM_LVL3 = 2'b10
   } fsbm_level_t;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        boot;
      logic [15:0] addr;
   } fsbm_acc_t;
endpackage

// ### fsbm_prog_model.sv
// Purpose: parallel programmer at the far side
// Assumes: cmd changes at a rising edge
// Notes:   0 off, 1 erase, 2 program, 3 verify
`timescale 1ns/1ps
module fsbm_prog_model
   import fsbm_pkg::*;
(
   // command and pins
   input wire logic       clk,
   input wire logic [1:0] cmd,
   output logic           hw_mode,
   output logic           hw_erase,
   output fsbm_acc_t      hw_acc
);
   logic [1:0] cmd_reg = '0; // one cycle of tool latency
   always @(posedge clk) cmd_reg <= cmd;
   // request held for as long as the command stands
   assign hw_mode  = cmd_reg != 2'h0;
   assign hw_erase = cmd_reg == 2'h1;
   assign hw_acc   = '{rd: cmd_reg == 2'h3, wr: cmd_reg == 2'h2, boot: 1'b0, addr: 16'h0100};
endmodule

// ### fsbm_top.sv
// Purpose: flash security levels, boot mapping and aux register
// Assumes: nonvolatile bytes held here; a programmed bit is 0
// Notes:   flash array and its timing live outside
`timescale 1ns/1ps
`include "fsbm_defs.svh"
module fsbm_top
   import fsbm_pkg::*;
(
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   // register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [7:0]  REG_RDATA,
   // boot force pin, asynchronous
   input  wire logic        BOOT_FORCE_PIN_N,
   // flash access requests
   input  fsbm_acc_t        SW_ACC,
   input  fsbm_acc_t        HW_ACC,
   input  wire logic        HW_MODE,
   input  wire logic        HW_CHIP_ERASE,
   input  wire logic        EXT_FETCH,
   // decisions
   output logic             SW_GRANT,
   output logic             HW_GRANT,
   output logic             EXT_EXEC_EN,
   output logic             BOOT_MAPPED,
   output logic             DATA_PTR_SEL,
   output logic             DOUBLE_SPEED_MODE,
   output logic      [15:0] RESET_VECTOR,
   output logic      [8:0]  PAGE_NUM
);
   // ****************************************
   // synchroniser
   // ****************************************
   logic pin_meta_reg;
   logic pin_sync_reg;
   // pin crosses in before anything reads it
   always_ff @(posedge REF_CLK) begin
      pin_meta_reg <= BOOT_FORCE_PIN_N;
      pin_sync_reg <= pin_meta_reg;
   end

   // ****************************************
   // state
   // ****************************************
   logic       boot_en_reg, gflag_reg, dps_reg, x2_reg, rst_d_reg;
   logic [1:0] hsb_msn_reg;                 // x2b, jump bit
   logic [1:0] lock_reg;                    // lb1, lb0 only
   logic [7:0] sbv_reg, ssb_reg;
   logic [15:0] vec_reg;

   function automatic fsbm_level_t level_of(input logic [1:0] lb);
      // lb2 never stored so reads unprogrammed; top programmed bit wins
      if (!lb[1])      level_of = FSBM_LVL2;
      else if (!lb[0]) level_of = FSBM_LVL1;
      else             level_of = FSBM_LVL0;
   endfunction

   // ****************************************
   // decode
   // ****************************************
   wire fsbm_level_t lvl   = level_of(lock_reg);
   wire logic        wr_aux = REG_WR && REG_ADDR == `FSBM_AUX1_OFF;
   wire logic        wr_hsb = REG_WR && REG_ADDR == `FSBM_HSB_OFF;
   wire logic        wr_sbv = REG_WR && REG_ADDR == `FSBM_SBV_OFF;
   wire logic        wr_ssb = REG_WR && REG_ADDR == `FSBM_SSB_OFF;
   wire logic        hw_prog_ok = lvl == FSBM_LVL0;
   wire logic        hw_ver_ok  = lvl == FSBM_LVL0 || lvl == FSBM_LVL1;
   wire logic        ext_ok     = lvl != FSBM_LVL3;
   // software never touches boot space; always allowed on user space
   wire logic sw_ok = (SW_ACC.rd || SW_ACC.wr) && !SW_ACC.boot;
   wire logic hw_ok = HW_MODE && ((HW_ACC.wr && hw_prog_ok)
                      || (HW_ACC.rd && hw_ver_ok));
   // pin low or jump bit programmed selects boot at reset
   wire logic boot_cond = !pin_sync_reg || !hsb_msn_reg[0];
   wire logic [7:0] hsb_view = {hsb_msn_reg, 3'b111, 1'b1, lock_reg};
   wire logic [7:0] aux_view = {2'b00, boot_en_reg, 1'b0, gflag_reg,
                                1'b0, 1'b0, dps_reg};
   wire logic [7:0] stat_view = {5'h00, ext_ok, hw_ver_ok, hw_prog_ok};
   logic [7:0] rd_mux;
   // read selection, unmapped reads give zero
   always_comb begin
      case (REG_ADDR)
         `FSBM_AUX1_OFF: rd_mux = aux_view;
         `FSBM_HSB_OFF:  rd_mux = hsb_view;
         `FSBM_SBV_OFF:  rd_mux = sbv_reg;
         `FSBM_SSB_OFF:  rd_mux = ssb_reg;
         `FSBM_STAT_OFF: rd_mux = stat_view;
         default:        rd_mux = 8'h00;
      endcase
   end

   // ****************************************
   // nonvolatile bytes
   // ****************************************
   // reset keeps them; only erase or writes change them
   always_ff @(posedge REF_CLK) begin
      if (HW_MODE && HW_CHIP_ERASE) begin
         hsb_msn_reg <= 2'b11;
         lock_reg    <= 2'b11;
         sbv_reg     <= `FSBM_ERASED;
         ssb_reg     <= `FSBM_ERASED;
      end else begin
         if (wr_hsb) hsb_msn_reg <= REG_WDATA[7:6];
         if (wr_hsb && HW_MODE) lock_reg <= REG_WDATA[1:0];
         if (wr_sbv) sbv_reg <= REG_WDATA;
         if (wr_ssb) ssb_reg <= REG_WDATA;
      end
   end

   // ****************************************
   // aux register and reset sampling
   // ****************************************
   // reset-time capture happens on first clock after release
   always_ff @(posedge REF_CLK) begin
      rst_d_reg <= SYS_RST;
      if (SYS_RST) begin
         boot_en_reg <= 1'b0;
         gflag_reg   <= 1'b0;
         dps_reg     <= 1'b0;
         x2_reg      <= 1'b0;
         vec_reg     <= `FSBM_USER_VEC;
      end else if (rst_d_reg) begin
         boot_en_reg <= boot_cond;
         vec_reg     <= boot_cond ? `FSBM_BOOT_BASE : `FSBM_USER_VEC;
         x2_reg      <= !hsb_msn_reg[1];
      end else if (wr_aux) begin
         boot_en_reg <= REG_WDATA[`FSBM_AUX_BOOT];
         gflag_reg   <= REG_WDATA[`FSBM_AUX_GF];
         dps_reg     <= REG_WDATA[`FSBM_AUX_DPS];
      end
   end

   // ****************************************
   // outputs, all registered
   // ****************************************
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         REG_RDATA <= 8'h00; SW_GRANT <= 1'b0; HW_GRANT <= 1'b0;
         EXT_EXEC_EN <= 1'b0; BOOT_MAPPED <= 1'b0; DATA_PTR_SEL <= 1'b0;
         DOUBLE_SPEED_MODE <= 1'b0; RESET_VECTOR <= `FSBM_USER_VEC; PAGE_NUM <= 9'h000;
      end else begin
         REG_RDATA         <= REG_RD ? rd_mux : 8'h00;
         SW_GRANT          <= sw_ok;
         HW_GRANT          <= hw_ok;
         EXT_EXEC_EN       <= EXT_FETCH && ext_ok;
         // boot hits only the top 4K when mapped
         BOOT_MAPPED       <= boot_en_reg;
         DATA_PTR_SEL      <= dps_reg;
         DOUBLE_SPEED_MODE <= x2_reg;
         RESET_VECTOR      <= vec_reg;
         PAGE_NUM          <= SW_ACC.addr[15:7];
      end
   end
endmodule

// ### fsbm_top_monitor.sv
// Purpose: port checks of the flash security block
// Assumes: bytes erased before any check fires
// Notes:   level three is never reached here
`timescale 1ns/1ps
`include "fsbm_defs.svh"
module fsbm_top_monitor
   import fsbm_pkg::*;
(
   // watched ports
   input wire logic       REF_CLK,
   input wire logic       SYS_RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic       REG_WR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_RDATA,
   input fsbm_acc_t       SW_ACC,
   input wire logic       EXT_FETCH,
   input wire logic       SW_GRANT,
   input wire logic       EXT_EXEC_EN,
   input wire logic       BOOT_MAPPED,
   input wire logic       DATA_PTR_SEL,
   input wire logic [8:0] PAGE_NUM
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   // decodes; a write in the release cycle is lost, so skip it
   wire aux_wr = REG_WR && REG_ADDR == `FSBM_AUX1_OFF;
   wire aux_rd = REG_RD && REG_ADDR == `FSBM_AUX1_OFF;
   wire hsb_rd = REG_RD && REG_ADDR == `FSBM_HSB_OFF;
   property p_zero; aux_rd |=> REG_RDATA[2] == 1'b0; endproperty
   a_zero: assert property (p_zero) else $error("aux bit 2 not zero");
   property p_rsv; hsb_rd |=> REG_RDATA[5:3] == 3'h7; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits programmed");
   property p_map; aux_wr && !$past(SYS_RST) ##1 !aux_wr |=> BOOT_MAPPED == $past(REG_WDATA[5], 2);
   endproperty
   a_map: assert property (p_map) else $error("boot map not from write");
   property p_dps; aux_wr && !$past(SYS_RST) ##1 !aux_wr |=> DATA_PTR_SEL == $past(REG_WDATA[0], 2);
   endproperty
   a_dps: assert property (p_dps) else $error("pointer select not from write");
   property p_user; SW_ACC.rd && !SW_ACC.boot |=> SW_GRANT; endproperty
   a_user: assert property (p_user) else $error("software user read refused");
   property p_boot; SW_ACC.boot |=> !SW_GRANT; endproperty
   a_boot: assert property (p_boot) else $error("software reached boot space");
   property p_ext; EXT_FETCH |=> EXT_EXEC_EN; endproperty
   a_ext: assert property (p_ext) else $error("external fetch refused");
   property p_page; SW_ACC.rd |=> PAGE_NUM == $past(SW_ACC.addr[15:7]); endproperty
   a_page: assert property (p_page) else $error("page number wrong");
endmodule
bind fsbm_top fsbm_top_monitor mon (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .SW_ACC(SW_ACC), .EXT_FETCH(EXT_FETCH), .SW_GRANT(SW_GRANT),
   .EXT_EXEC_EN(EXT_EXEC_EN), .BOOT_MAPPED(BOOT_MAPPED), .DATA_PTR_SEL(DATA_PTR_SEL),
   .PAGE_NUM(PAGE_NUM));

// ### fsbm_top_tb.sv
// Purpose: self-checking bench of fsbm_top
// Assumes: 200 MHz clock, synchronous reset
// Notes:   nonvolatile bytes erased before use
`timescale 1ns/1ps
`include "fsbm_defs.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
module fsbm_top_tb
   import fsbm_pkg::*;
   ;
   logic        clk = 0, rst = 1, wr = 0, rd = 0, pin_n = 1, ext = 0;
   logic [7:0]  addr = '0, wdata = '0, rdata;
   logic [1:0]  cmd = '0;
   fsbm_acc_t   sw = '0, hw_acc;
   logic        hw_mode, hw_erase, sw_gnt, hw_gnt, ext_en, mapped, data_pointer_select, x2;
   logic [15:0] vec;
   logic [8:0]  page;
   int          num_errors = 0, check_count = 0;
   initial forever #2.5 clk = ~clk;
   fsbm_top uut (.REF_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .BOOT_FORCE_PIN_N(pin_n), .SW_ACC(sw),
      .HW_ACC(hw_acc), .HW_MODE(hw_mode), .HW_CHIP_ERASE(hw_erase), .EXT_FETCH(ext),
      .SW_GRANT(sw_gnt), .HW_GRANT(hw_gnt), .EXT_EXEC_EN(ext_en), .BOOT_MAPPED(mapped),
      .DATA_PTR_SEL(data_pointer_select), .DOUBLE_SPEED_MODE(x2), .RESET_VECTOR(vec), .PAGE_NUM(page));
   fsbm_prog_model prog (.clk(clk), .cmd(cmd), .hw_mode(hw_mode), .hw_erase(hw_erase),
      .hw_acc(hw_acc));
   // bus cycles: strobe for one edge, read data the cycle after
   task automatic step(int n); repeat (n) @(posedge clk); endtask
   task automatic wreg(logic [7:0] a, d);
      @(posedge clk); wr <= 1; addr <= a; wdata <= d;
      @(posedge clk); wr <= 0;
   endtask
   task automatic rreg(logic [7:0] a, e);
      @(posedge clk); rd <= 1; addr <= a;
      @(posedge clk); rd <= 0; #1 `CHK("rdata", e, rdata)
   endtask
   task automatic do_reset(logic p);
      @(posedge clk); pin_n <= p; rst <= 1; step(4); rst <= 0; step(4); #1;
   endtask
   task automatic t_erase;
      @(posedge clk); cmd <= 2'h1; step(3); cmd <= 2'h0; step(2);
      for (int i = 0; i < 3; i++) rreg(`FSBM_HSB_OFF + 8'(i), 8'hff);
   endtask
   task automatic t_aux;
      wreg(`FSBM_AUX1_OFF, 8'hff); rreg(`FSBM_AUX1_OFF, 8'h29);
      `CHK("mapped", 1'b1, mapped)
      `CHK("dps", 1'b1, data_pointer_select)
      wreg(`FSBM_AUX1_OFF, 8'h00); rreg(`FSBM_AUX1_OFF, 8'h00);
      `CHK("mapped", 1'b0, mapped)
      `CHK("dps", 1'b0, data_pointer_select)
      wreg(`FSBM_SBV_OFF, 8'h5a); rreg(`FSBM_SBV_OFF, 8'h5a);
      wreg(`FSBM_SSB_OFF, 8'ha5); rreg(`FSBM_SSB_OFF, 8'ha5);
      rreg(`FSBM_STAT_OFF, 8'h07);
   endtask
   // lock nibble only moves in hardware mode; grants follow the level
   task automatic t_lock;
      wreg(`FSBM_HSB_OFF, 8'h00); rreg(`FSBM_HSB_OFF, 8'h3f);
      @(posedge clk); cmd <= 2'h2; step(3); #1 `CHK("hw_gnt", 1'b1, hw_gnt)
      wreg(`FSBM_HSB_OFF, 8'h3e); step(3); #1 `CHK("hw_gnt", 1'b0, hw_gnt)
      @(posedge clk); cmd <= 2'h3; step(3); #1 `CHK("hw_gnt", 1'b1, hw_gnt)
      wreg(`FSBM_HSB_OFF, 8'h3d); step(3); #1 `CHK("hw_gnt", 1'b0, hw_gnt)
      rreg(`FSBM_HSB_OFF, 8'h3d);
      rreg(`FSBM_STAT_OFF, 8'h04);
      @(posedge clk); cmd <= 2'h0; sw <= '{rd: 1'b1, wr: 1'b0, boot: 1'b0, addr: 16'hff80};
      ext <= 1; step(2); #1 `CHK("sw_gnt", 1'b1, sw_gnt)
      `CHK("page", 9'h1ff, page)
      `CHK("ext_en", 1'b1, ext_en)
      @(posedge clk); sw.boot <= 1; step(2); #1 `CHK("sw_gnt", 1'b0, sw_gnt)
   endtask
   task automatic t_boot;
      do_reset(1); `CHK("vec", 16'hf000, vec)
      `CHK("x2", 1'b1, x2)
      `CHK("mapped", 1'b1, mapped)
      t_erase(); do_reset(0); `CHK("vec", 16'hf000, vec)
      `CHK("x2", 1'b0, x2)
      rreg(`FSBM_AUX1_OFF, 8'h20);
      do_reset(1); `CHK("vec", 16'h0000, vec)
      `CHK("mapped", 1'b0, mapped)
      rreg(`FSBM_AUX1_OFF, 8'h00);
   endtask
   task automatic end_of_test;
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin #100000; num_errors++; end_of_test(); end
   initial begin
      step(12); rst <= 0; step(2);
      t_erase(); t_aux(); t_lock(); t_boot(); end_of_test();
   end
endmodule
